// *** rtl/acv_pkg.sv ***
`default_nettype none
package acv_pkg;
    // Result widths
    localparam int WORD_BITS = 16;
    localparam int DATA_BITS = 14;
    // Edge counts that bound the windows
    localparam logic [4:0] EDGE_PD_LO = 5'h02;
    localparam logic [4:0] EDGE_PD_HI = 5'h0a;
    localparam logic [4:0] EDGE_TRACK = 5'h0f;
    localparam logic [4:0] EDGE_DONE = 5'h10;
    // Timing of the host
    localparam int CLK_HZ = 40000000;
    localparam int SCLK_HZ = 2500000;
    localparam int HALF_DIV = CLK_HZ / (2 * SCLK_HZ);
    localparam logic [3:0] HALF_CYC = 4'(HALF_DIV);
    localparam int QUIET_NS = 100;
    localparam logic [3:0] QUIET_CYC = 4'((QUIET_NS * 40 + 999) / 1000);
    // Host frame lengths
    localparam logic [4:0] FRAME_FULL = 5'h10;
    localparam logic [4:0] FRAME_SLEEP = 5'h08;
endpackage
`default_nettype wire

// *** rtl/acv_link_if.sv ***
`default_nettype none
// Link between host and converter: select, shift clock, data pin
interface acv_link_if;
    logic selN;           // Frame select, active low
    logic sclk;           // Shift clock from host
    logic resultOut;      // Serial result data level
    logic resultOe;       // High while converter drives data
    modport dev (input selN, input sclk, output resultOut,
        output resultOe);
    modport host (output selN, output sclk, input resultOut,
        input resultOe);
endinterface
`default_nettype wire

// *** rtl/acv_device.sv ***
`default_nettype none
// Converter end: samples link pins on clk, keeps frame state
module acv_device
    import acv_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    acv_link_if.dev link,
    input wire logic [DATA_BITS-1:0] sampleIn,
    output logic poweredUp,
    output logic analogOn,
    output logic tracking,
    output logic validNext
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] selSync_reg;   // Three stages of select
    logic [2:0] sclkSync_reg;  // Three stages of shift clock
    logic selState_reg;        // Filtered select level
    logic sclkState_reg;       // Filtered clock level
    // Shift in pins each cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            selSync_reg <= 3'h7;
            // Shift clock idles high, so no false edge after reset
            sclkSync_reg <= 3'h7;
        end else begin
            selSync_reg <= {selSync_reg[1:0], link.selN};
            sclkSync_reg <= {sclkSync_reg[1:0], link.sclk};
        end
    end
    // Accept level once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            selState_reg <= 1'b1;
            sclkState_reg <= 1'b1;
        end else begin
            if (selSync_reg[1] == selSync_reg[2]) begin
                selState_reg <= selSync_reg[2];
            end
            if (sclkSync_reg[1] == sclkSync_reg[2]) begin
                sclkState_reg <= sclkSync_reg[2];
            end
        end
    end
    logic selFall, selRise, sclkFall, sclkRise;
    assign selFall = selState_reg && !selSync_reg[2]
        && selSync_reg[1] == selSync_reg[2];
    assign selRise = !selState_reg && selSync_reg[2]
        && selSync_reg[1] == selSync_reg[2];
    assign sclkFall = sclkState_reg && !sclkSync_reg[2]
        && sclkSync_reg[1] == sclkSync_reg[2];
    assign sclkRise = !sclkState_reg && sclkSync_reg[2]
        && sclkSync_reg[1] == sclkSync_reg[2];

    // ****************************************
    // Frame edge counter
    // ****************************************
    logic [4:0] edgeCnt_reg;   // Shift clock falls in frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edgeCnt_reg <= 5'h00;
        end else if (selState_reg || selFall) begin
            edgeCnt_reg <= 5'h00;
        end else if (sclkFall && edgeCnt_reg != 5'h1f) begin
            edgeCnt_reg <= edgeCnt_reg + 5'h01;
        end
    end

    // ****************************************
    // Conversion and shift register
    // ****************************************
    logic out_reg;                    // Data pin level
    logic [3:0] outIdx;               // Result bit due at this fall
    logic [DATA_BITS-1:0] held_reg;   // Held sample
    logic [DATA_BITS-1:0] sar_reg;    // Approximation register
    logic [3:0] bitIdx_reg;           // Bit under trial
    // sample on select fall, SAR steps on shift clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            held_reg <= '0;
            sar_reg <= '0;
            bitIdx_reg <= 4'h0;
        end else if (selFall) begin
            held_reg <= sampleIn;
            sar_reg <= '0;
            bitIdx_reg <= 4'(DATA_BITS - 1);
        end else if (sclkRise && !selState_reg && bitIdx_reg != 4'hf) begin
            // straight binary trial, one code per LSB
            if ((sar_reg | (14'h0001 << bitIdx_reg)) <= held_reg) begin
                sar_reg <= sar_reg | (14'h0001 << bitIdx_reg);
            end
            bitIdx_reg <= bitIdx_reg - 4'h1;
        end
    end
    // Bit settled by the rise before this fall
    assign outIdx = 4'(EDGE_TRACK - 5'h01 - edgeCnt_reg);
    // two zeros then MSB first; select fall presents first zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_reg <= 1'b0;
        end else if (selFall) begin
            // First leading zero
            out_reg <= 1'b0;
        end else if (sclkFall && !selState_reg) begin
            // present the bit the approximation just decided
            if (edgeCnt_reg == 5'h00 || edgeCnt_reg >= EDGE_TRACK) begin
                out_reg <= 1'b0;
            end else begin
                out_reg <= sar_reg[outIdx];
            end
        end
    end
    assign link.resultOut = out_reg;

    // ****************************************
    // Output enable
    // ****************************************
    logic oe_reg;  // Data pin driven
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oe_reg <= 1'b0;
        end else if (selFall) begin
            oe_reg <= 1'b1;
        end else if (sclkFall && edgeCnt_reg == EDGE_DONE - 5'h01) begin
            oe_reg <= 1'b0;
        end else if (selRise) begin
            oe_reg <= 1'b0;
        end
    end
    assign link.resultOe = oe_reg;

    // ****************************************
    // Power mode
    // ****************************************
    typedef enum logic [1:0] {
        PM_ON = 2'b00,
        PM_DOWN = 2'b01,
        PM_WAKE = 2'b10
    } acv_pm_e;
    acv_pm_e pm_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pm_reg <= PM_ON;
            validNext <= 1'b1;
        end else begin
            unique case (pm_reg)
                PM_ON: begin
                    // window two to nine; below two stays on
                    if (selRise && edgeCnt_reg >= EDGE_PD_LO
                        && edgeCnt_reg < EDGE_PD_HI) begin
                        pm_reg <= PM_DOWN;
                        validNext <= 1'b0;
                    end else if (selFall) begin
                        validNext <= 1'b1;
                    end
                end
                PM_DOWN: begin
                    // power up begins on select fall
                    if (selFall) begin
                        pm_reg <= PM_WAKE;
                    end
                end
                PM_WAKE: begin
                    if (selRise && edgeCnt_reg < EDGE_PD_HI) begin
                        pm_reg <= PM_DOWN;
                    // awake after sixteen falls, or select rise after ten; next conversion valid
                    end else if (edgeCnt_reg >= EDGE_DONE
                        || (selRise && edgeCnt_reg >= EDGE_PD_HI)) begin
                        pm_reg <= PM_ON;
                        validNext <= 1'b1;
                    end
                end
                default: pm_reg <= PM_DOWN;
            endcase
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            analogOn <= 1'b1;
            poweredUp <= 1'b1;
        end else begin
            analogOn <= (pm_reg != PM_DOWN);
            poweredUp <= (pm_reg == PM_ON);
        end
    end
    // track after fifteen falls on next rise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tracking <= 1'b1;
        end else if (selFall) begin
            tracking <= 1'b0;
        end else if (sclkRise && edgeCnt_reg >= EDGE_TRACK) begin
            tracking <= 1'b1;
        end else if (selRise) begin
            tracking <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** rtl/acv_host.sv ***
`default_nettype none
// Host end: makes select and shift clock, gathers result word
module acv_host
    import acv_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    acv_link_if.host link,
    input wire logic startFull,
    input wire logic startSleep,
    output logic busy,
    output logic [WORD_BITS-1:0] word,
    output logic wordValid
);
    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_RUN = 2'b01,
        HS_QUIET = 2'b10
    } acv_hs_e;
    acv_hs_e st_reg;
    logic [3:0] div_reg;       // Half period count
    logic [4:0] edges_reg;     // Falls issued
    logic [4:0] limit_reg;     // Falls wanted this frame
    logic selN_reg, sclk_reg;
    logic [WORD_BITS-1:0] rx_reg;
    // ****************************************
    // Frame sequencer
    // ****************************************
    // 2.5 MHz shift clock; frame length
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= HS_IDLE;
            div_reg <= 4'h0;
            edges_reg <= 5'h00;
            limit_reg <= FRAME_FULL;
            selN_reg <= 1'b1;
            sclk_reg <= 1'b1;
            rx_reg <= '0;
            word <= '0;
            wordValid <= 1'b0;
            busy <= 1'b0;
        end else begin
            wordValid <= 1'b0;
            unique case (st_reg)
                HS_IDLE: begin
                    if (startFull || startSleep) begin
                        limit_reg <= startSleep ? FRAME_SLEEP : FRAME_FULL;
                        selN_reg <= 1'b0;
                        busy <= 1'b1;
                        div_reg <= HALF_CYC - 4'h1;
                        edges_reg <= 5'h00;
                        st_reg <= HS_RUN;
                    end
                end
                HS_RUN: begin
                    if (div_reg != 4'h0) begin
                        div_reg <= div_reg - 4'h1;
                    end else if (sclk_reg) begin
                        // Capture bit then drop clock
                        // Released pin reads as low
                        rx_reg <= {rx_reg[WORD_BITS-2:0],
                            link.resultOut && link.resultOe};
                        sclk_reg <= 1'b0;
                        edges_reg <= edges_reg + 5'h01;
                        div_reg <= HALF_CYC - 4'h1;
                    end else if (edges_reg == limit_reg) begin
                        selN_reg <= 1'b1;
                        sclk_reg <= 1'b1;
                        word <= rx_reg;
                        wordValid <= (limit_reg == FRAME_FULL);
                        div_reg <= QUIET_CYC;
                        st_reg <= HS_QUIET;
                    end else begin
                        sclk_reg <= 1'b1;
                        div_reg <= HALF_CYC - 4'h1;
                    end
                end
                HS_QUIET: begin
                    if (div_reg != 4'h0) begin
                        div_reg <= div_reg - 4'h1;
                    end else begin
                        busy <= 1'b0;
                        st_reg <= HS_IDLE;
                    end
                end
                default: st_reg <= HS_IDLE;
            endcase
        end
    end
    assign link.selN = selN_reg;
    assign link.sclk = sclk_reg;
endmodule
`default_nettype wire

// *** sim/acv_link_properties.sv ***
`default_nettype none
// Watches the link between host and converter ends
module acv_link_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic selN,
    input wire logic sclk,
    input wire logic resultOut,
    input wire logic resultOe
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Falls per frame
    // ****
    logic [4:0] fallCnt; // Falls so far
    logic sclkQ; // Shift clock one cycle ago
    wire logic fallNow = sclkQ && !sclk && !selN; // Fall in frame
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fallCnt <= 5'h00;
            sclkQ <= 1'b1;
        end else begin
            sclkQ <= sclk;
            if (selN) begin
                fallCnt <= 5'h00;
            end else if (fallNow) begin
                fallCnt <= fallCnt + 5'h01;
            end
        end
    end
    // ****
    // Link checks
    // ****
    sel_fall_drive_a: assert property ($fell(selN) |-> ##[1:6] resultOe)
        else $error("data not driven after select fall");
    first_zero_a: assert property ($rose(resultOe) |-> !resultOut)
        else $error("first bit not zero");
    second_zero_a: assert property (fallNow && fallCnt == 5'h00
        |-> ##6 (resultOe && !resultOut))
        else $error("second bit not zero");
    release_16_a: assert property (fallNow && fallCnt == 5'h0f
        |-> ##[1:6] !resultOe) else $error("no release at 16th fall");
    abort_release_a: assert property ($rose(selN) |-> ##[1:6] !resultOe)
        else $error("no release at select rise");
    idle_quiet_a: assert property (selN [*8] |-> !resultOe)
        else $error("data driven while deselected");
    idle_clock_a: assert property (selN [*4] |-> sclk)
        else $error("shift clock moves outside frame");
    frame_len_a: assert property ($rose(selN)
        |-> (fallCnt == 5'h10 || fallCnt == 5'h08))
        else $error("frame length wrong");
    half_period_a: assert property ($fell(sclk)
        |-> !sclk [*8] ##1 sclk) else $error("shift clock period wrong");
    full_frame_c: cover property ($rose(selN) && fallCnt == 5'h10);
    sleep_frame_c: cover property ($rose(selN) && fallCnt == 5'h08);
    data_one_c: cover property (resultOe && resultOut);
endmodule
`default_nettype wire

// *** sim/adc_serial_power_mode_control_tb_top.sv ***
`default_nettype none
// Both ends joined; second device driven by the bench
module adc_serial_power_mode_control_tb_top
    import acv_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Signals
    // ****
    logic clk, rst_n = 1'b1, startFull = 1'b0, startSleep = 1'b0;
    logic [DATA_BITS-1:0] sampleIn = 14'h0000; // Input stand-in
    logic busy, wordValid, poweredUp, analogOn, tracking, validNext, pwrB;
    logic [WORD_BITS-1:0] word;
    int errors = 0, tests_run = 0, pwr = 1, pwrB_exp = 1, expQ[$];
    int vals[4] = '{0, 16383, 8192, 1}; // Boundary samples
    int kTab[7] = '{1, 12, 5, 1, 3, 12, 16}; // Falls before rise
    acv_link_if link();
    acv_link_if linkB();
    acv_host i_acv_host (.clk(clk), .rst_n(rst_n), .link(link),
        .startFull(startFull), .startSleep(startSleep), .busy(busy),
        .word(word), .wordValid(wordValid));
    acv_device i_acv_device (.clk(clk), .rst_n(rst_n), .link(link),
        .sampleIn(sampleIn), .poweredUp(poweredUp), .analogOn(analogOn),
        .tracking(tracking), .validNext(validNext));
    acv_device i_acv_device_b (.clk(clk), .rst_n(rst_n), .link(linkB),
        .sampleIn(sampleIn), .poweredUp(pwrB), .analogOn(),
        .tracking(), .validNext());
    acv_link_properties i_props (.clk(clk), .rst_n(rst_n),
        .selN(link.selN), .sclk(link.sclk), .resultOut(link.resultOut),
        .resultOe(link.resultOe));
    // Clock, 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ****
    // Tasks
    // ****
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Power model: frame of k falls
    function automatic int nextPwr(input int p, input int k);
        if (k >= 10) return 1;
        if (p == 0 || k >= 2) return 0;
        return p;
    endfunction
    // One host frame; full frames may check the word
    task automatic hostFrame(input bit full, input bit chk, input int v);
        int n;
        @(negedge clk);
        sampleIn = 14'(v);
        if (full && chk) expQ.push_back({2'b00, sampleIn});
        startFull = full;
        startSleep = !full;
        @(negedge clk);
        startFull = 1'b0;
        startSleep = 1'b0;
        for (n = 0; n < 600; n++) begin
            @(posedge clk);
            #1;
            if (wordValid === 1'b1 && expQ.size() > 0)
                check(word, 16'(expQ.pop_front()));
            if (busy === 1'b0) break;
        end
        if (n == 600) begin
            errors++;
            give_verdict();
        end
        repeat (4) @(negedge clk);
        pwr = full ? 1 : 0;
        check(poweredUp, 16'(pwr));
        check(analogOn, 16'(pwr));
        if (full) check(tracking, 16'h0001);
    endtask
    // Bench frame on second link: k falls then rise
    task automatic benchFrame(input int k);
        linkB.selN = 1'b0;
        repeat (8) @(negedge clk);
        repeat (k) begin
            linkB.sclk = 1'b0;
            repeat (8) @(negedge clk);
            linkB.sclk = 1'b1;
            repeat (8) @(negedge clk);
        end
        linkB.selN = 1'b1;
        repeat (16) @(negedge clk);
        pwrB_exp = nextPwr(pwrB_exp, k);
        check(pwrB, 16'(pwrB_exp));
        check(linkB.resultOe, 16'h0000);
    endtask
    // ****
    // Main sequence
    // ****
    initial begin
        void'($urandom(66342));
        linkB.selN = 1'b1;
        linkB.sclk = 1'b1;
        // Real falling edge on reset so every register clears
        @(posedge clk);
        @(negedge clk);
        rst_n = 1'b0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check(poweredUp, 16'h0001);
        check(busy, 16'h0000);
        foreach (vals[i]) hostFrame(1'b1, 1'b1, vals[i]);
        repeat (4) hostFrame(1'b1, 1'b1, int'($urandom));
        hostFrame(1'b0, 1'b0, 0);
        hostFrame(1'b0, 1'b0, 0);
        check(validNext, 16'h0000);
        hostFrame(1'b1, 1'b0, 0);
        check(validNext, 16'h0001);
        hostFrame(1'b1, 1'b1, int'($urandom));
        foreach (kTab[i]) benchFrame(kTab[i]);
        give_verdict();
    end
endmodule
`default_nettype wire
